// >>> src/psab_pkg.sv
// Function
// R1: program space is handled as 24-bit words and data space as 16-bit words, with alignment kept.
// R2: a table access address is the 8-bit table page joined above the full 16-bit effective address.
// R3: the top bit of the table page picks user memory (0) or configuration memory (1).
// R4: a data address with its top bit set maps to the window page joined to the low 15 address bits.
// R5: window accesses always have program address bit 23 forced to zero, so user memory only.
// R6: writes that land in the remap window never modify program memory.
// R7: a window read returns only the low 16-bit word of the program word.
// R8: table reads and writes reach any byte or the low word of any program word.
// R9: an instruction fetch address is zero on top, counter bits 22..1 in the middle, zero at bit 0.
// R10: program address bit 15 of a window access comes from bit 0 of the window page.
// R11: data addresses with the top bit clear go to data space untranslated.
package psab_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int PSAB_PA_W    = 24;
	localparam int PSAB_EA_W    = 16;
	localparam int PSAB_DW      = 16;
	localparam int PSAB_PAGE_W  = 8;
	localparam int PSAB_WIN_W   = 15;
	localparam int PSAB_PC_W    = 23;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int PSAB_EA_TOP  = 15;
	localparam int PSAB_CFG_BIT = 23;
	localparam logic [PSAB_PAGE_W-1:0] PSAB_PAGE_RST  = 8'h00;
	localparam logic [2:0]             PSAB_LANE_NONE = 3'h0;
	localparam logic [2:0]             PSAB_LANE_LSW  = 3'h3;
	localparam logic [2:0]             PSAB_LANE_B0   = 3'h1;
	localparam logic [2:0]             PSAB_LANE_B1   = 3'h2;
	localparam logic [2:0]             PSAB_LANE_B2   = 3'h4;
	localparam logic [7:0]             PSAB_ZB        = 8'h00;

	// core operations
	typedef enum logic [2:0] {
		PSAB_OP_FETCH = 3'h0,
		PSAB_OP_DRD   = 3'h1,
		PSAB_OP_DWR   = 3'h2,
		PSAB_OP_TRD   = 3'h3,
		PSAB_OP_TWR   = 3'h4
	} psab_op_t;

	// how read data is picked out of the returned program word
	typedef enum logic [1:0] {
		PSAB_SEL_LSW  = 2'h0,
		PSAB_SEL_B0   = 2'h1,
		PSAB_SEL_B1   = 2'h2,
		PSAB_SEL_B2   = 2'h3
	} psab_sel_t;

	typedef enum logic [1:0] {
		PSAB_ST_IDLE = 2'b01,
		PSAB_ST_WAIT = 2'b10
	} psab_state_t;

endpackage

// >>> src/psab_pages.sv
`timescale 1ns/1ps
// holds the table page and window page registers written by the core
module psab_pages
	import psab_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   table_page_we,
	input  wire logic                   window_page_we,
	input  wire logic [PSAB_PAGE_W-1:0] page_wdata,
	output logic      [PSAB_PAGE_W-1:0] table_page_reg,
	output logic      [PSAB_PAGE_W-1:0] window_page_reg
);

	typedef struct packed {
		logic [PSAB_PAGE_W-1:0] tbl;
		logic [PSAB_PAGE_W-1:0] win;
	} psab_pg_t;

	psab_pg_t pg_r;
	psab_pg_t pg_nxt;

	// ---------------------------------------------------------------
	// page update
	// ---------------------------------------------------------------
	always_comb begin
		pg_nxt = pg_r;
		if (table_page_we) begin
			pg_nxt.tbl = page_wdata;
		end
		if (window_page_we) begin
			pg_nxt.win = page_wdata;
		end
	end

	// both pages clear at reset: user memory, page zero
	always_ff @(posedge clk) begin
		if (srst) begin
			pg_r <= '{tbl: PSAB_PAGE_RST, win: PSAB_PAGE_RST};
		end else begin
			pg_r <= pg_nxt;
		end
	end

	assign table_page_reg  = pg_r.tbl;
	assign window_page_reg = pg_r.win;

endmodule

// >>> src/psab_top.sv
`timescale 1ns/1ps
// turns core data addresses into program-memory or data-memory accesses
module psab_top
	import psab_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	// core request side
	input  wire logic                   req_valid,
	input  wire psab_op_t               req_op,
	input  wire logic [PSAB_EA_W-1:0]   req_ea,
	input  wire logic [PSAB_PC_W-1:0]   req_pc,
	input  wire logic                   req_byte,
	input  wire logic                   req_hi,
	input  wire logic [PSAB_DW-1:0]     req_wdata,
	output logic                        req_ready,
	// page register writes
	input  wire logic                   table_page_we,
	input  wire logic                   window_page_we,
	input  wire logic [PSAB_PAGE_W-1:0] page_wdata,
	output logic      [PSAB_PAGE_W-1:0] table_page_reg,
	output logic      [PSAB_PAGE_W-1:0] window_page_reg,
	// core answer side
	output logic                        rsp_valid,
	output logic      [PSAB_DW-1:0]     rsp_rdata,
	output logic      [PSAB_PA_W-1:0]   rsp_instr,
	output logic                        window_wr_drop,
	// program memory side
	output logic                        pm_rd,
	output logic                        pm_wr,
	output logic      [PSAB_PA_W-1:0]   pm_addr,
	output logic      [2:0]             pm_lane,
	output logic      [PSAB_PA_W-1:0]   pm_wdata,
	input  wire logic                   pm_rvalid,
	input  wire logic [PSAB_PA_W-1:0]   pm_rdata,
	// data space side
	output logic                        ds_valid,
	output logic                        ds_wr,
	output logic      [PSAB_EA_W-1:0]   ds_addr,
	output logic      [PSAB_DW-1:0]     ds_wdata
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		psab_state_t             st;
		psab_sel_t               sel;
		logic                    fetch;
		logic                    ready;
		logic                    rsp_v;
		logic [PSAB_DW-1:0]      rdata;
		logic [PSAB_PA_W-1:0]    instr;
		logic                    drop;
		logic                    rd;
		logic                    wr;
		logic [PSAB_PA_W-1:0]    addr;
		logic [2:0]              lane;
		logic [PSAB_PA_W-1:0]    wdata;
		logic                    dv;
		logic                    dwr;
		logic [PSAB_EA_W-1:0]    daddr;
		logic [PSAB_DW-1:0]      dwdata;
	} psab_core_t;

	psab_core_t s_r;
	psab_core_t s_nxt;

	logic [PSAB_PAGE_W-1:0] tbl_pg;
	logic [PSAB_PAGE_W-1:0] win_pg;

	psab_pages u_pages (
		.clk             (clk),
		.srst            (srst),
		.table_page_we   (table_page_we),
		.window_page_we  (window_page_we),
		.page_wdata      (page_wdata),
		.table_page_reg  (tbl_pg),
		.window_page_reg (win_pg)
	);

	// ---------------------------------------------------------------
	// address forms
	// ---------------------------------------------------------------
	logic [PSAB_PA_W-1:0] fetch_addr;
	logic [PSAB_PA_W-1:0] table_addr;
	logic [PSAB_PA_W-1:0] win_addr;
	logic                 in_window;

	// fetch: top bit zero, counter word bits in the middle, lsb zero
	assign fetch_addr = {1'b0, req_pc[PSAB_PC_W-1:1], 1'b0}; // [R9] [R1]
	// table: page on top of the whole ea; page msb becomes bit 23
	assign table_addr = {tbl_pg, req_ea}; // [R2] [R3]
	// window: ea msb dropped, page bit 0 lands on bit 15, bit 23 held low
	assign win_addr   = {1'b0, win_pg, req_ea[PSAB_WIN_W-1:0]}; // [R4] [R5] [R10]
	assign in_window  = req_ea[PSAB_EA_TOP]; // [R4]

	// ---------------------------------------------------------------
	// lane and write placement for table accesses
	// ---------------------------------------------------------------
	logic [2:0]            t_lane;
	psab_sel_t             t_sel;
	logic [PSAB_PA_W-1:0]  t_wdata;

	// byte ops use ea bit 0 inside the low word; hi reaches the top byte
	always_comb begin
		if (req_hi) begin
			t_lane  = PSAB_LANE_B2; // [R8]
			t_sel   = PSAB_SEL_B2;
			t_wdata = {req_wdata[7:0], PSAB_ZB, PSAB_ZB};
		end else if (req_byte && req_ea[0]) begin
			t_lane  = PSAB_LANE_B1; // [R8]
			t_sel   = PSAB_SEL_B1;
			t_wdata = {PSAB_ZB, req_wdata[7:0], PSAB_ZB};
		end else if (req_byte) begin
			t_lane  = PSAB_LANE_B0; // [R8]
			t_sel   = PSAB_SEL_B0;
			t_wdata = {PSAB_ZB, PSAB_ZB, req_wdata[7:0]};
		end else begin
			t_lane  = PSAB_LANE_LSW;
			t_sel   = PSAB_SEL_LSW;
			t_wdata = {PSAB_ZB, req_wdata};
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic take;
	assign take = req_valid && s_r.ready;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.rsp_v = 1'b0;
		s_nxt.drop  = 1'b0;
		s_nxt.rd    = 1'b0;
		s_nxt.wr    = 1'b0;
		s_nxt.dv    = 1'b0;
		case (s_r.st)
			PSAB_ST_IDLE: begin
				if (take) begin
					case (req_op)
						PSAB_OP_FETCH: begin
							s_nxt.rd    = 1'b1;
							s_nxt.addr  = fetch_addr; // [R9]
							s_nxt.lane  = PSAB_LANE_LSW | PSAB_LANE_B2;
							// low word on rsp_rdata, never a stale byte pick
							s_nxt.sel   = PSAB_SEL_LSW;
							s_nxt.fetch = 1'b1;
							s_nxt.st    = PSAB_ST_WAIT;
						end
						PSAB_OP_DRD, PSAB_OP_DWR: begin
							if (!in_window) begin
								// plain data space, address passed as is
								s_nxt.dv     = 1'b1; // [R11]
								s_nxt.dwr    = (req_op == PSAB_OP_DWR);
								s_nxt.daddr  = req_ea;
								s_nxt.dwdata = req_wdata;
							end else if (req_op == PSAB_OP_DRD) begin
								s_nxt.rd    = 1'b1;
								s_nxt.addr  = win_addr; // [R4]
								s_nxt.lane  = PSAB_LANE_LSW; // [R7]
								s_nxt.sel   = PSAB_SEL_LSW; // [R7]
								s_nxt.fetch = 1'b0;
								s_nxt.st    = PSAB_ST_WAIT;
							end else begin
								// window is read only: no pm strobe, flag only
								s_nxt.drop = 1'b1; // [R6]
							end
						end
						PSAB_OP_TRD: begin
							s_nxt.rd    = 1'b1;
							s_nxt.addr  = table_addr; // [R2]
							s_nxt.lane  = t_lane;
							s_nxt.sel   = t_sel;
							s_nxt.fetch = 1'b0;
							s_nxt.st    = PSAB_ST_WAIT;
						end
						PSAB_OP_TWR: begin
							s_nxt.wr    = 1'b1; // [R8]
							s_nxt.addr  = table_addr; // [R2] [R3]
							s_nxt.lane  = t_lane;
							s_nxt.wdata = t_wdata;
						end
						default: begin
							s_nxt.st = PSAB_ST_IDLE;
						end
					endcase
				end
			end
			PSAB_ST_WAIT: begin
				// one read outstanding at a time keeps answers in order
				if (pm_rvalid) begin
					s_nxt.rsp_v = 1'b1;
					s_nxt.st    = PSAB_ST_IDLE;
					s_nxt.instr = s_r.fetch ? pm_rdata : s_r.instr;
					case (s_r.sel)
						PSAB_SEL_LSW: s_nxt.rdata = pm_rdata[15:0]; // [R7]
						PSAB_SEL_B0:  s_nxt.rdata = {PSAB_ZB, pm_rdata[7:0]};
						PSAB_SEL_B1:  s_nxt.rdata = {PSAB_ZB, pm_rdata[15:8]};
						PSAB_SEL_B2:  s_nxt.rdata = {PSAB_ZB, pm_rdata[23:16]};
						default:      s_nxt.rdata = pm_rdata[15:0];
					endcase
				end
			end
			default: begin
				s_nxt.st = PSAB_ST_IDLE;
			end
		endcase
		s_nxt.ready = (s_nxt.st == PSAB_ST_IDLE);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r       <= '0;
			s_r.st    <= PSAB_ST_IDLE;
			s_r.sel   <= PSAB_SEL_LSW;
			s_r.ready <= 1'b1;
			s_r.lane  <= PSAB_LANE_NONE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flops
	// ---------------------------------------------------------------
	assign req_ready       = s_r.ready;
	assign rsp_valid       = s_r.rsp_v;
	assign rsp_rdata       = s_r.rdata;
	assign rsp_instr       = s_r.instr;
	assign window_wr_drop  = s_r.drop;
	assign pm_rd           = s_r.rd;
	assign pm_wr           = s_r.wr;
	assign pm_addr         = s_r.addr;
	assign pm_lane         = s_r.lane;
	assign pm_wdata        = s_r.wdata;
	assign ds_valid        = s_r.dv;
	assign ds_wr           = s_r.dwr;
	assign ds_addr         = s_r.daddr;
	assign ds_wdata        = s_r.dwdata;
	assign table_page_reg  = tbl_pg;
	assign window_page_reg = win_pg;

endmodule

// >>> bench/psab_chk.sv
`timescale 1ns/1ps
// port checks for the address builder
module psab_chk
	import psab_pkg::*;
(
	input wire logic		clk,
	input wire logic		srst,
	input wire logic		req_valid,
	input wire psab_op_t		req_op,
	input wire logic [15:0]	req_ea,
	input wire logic [22:0]	req_pc,
	input wire logic		req_byte,
	input wire logic		req_hi,
	input wire logic		req_ready,
	input wire logic [7:0]	table_page_reg,
	input wire logic [7:0]	window_page_reg,
	input wire logic		rsp_valid,
	input wire logic [15:0]	rsp_rdata,
	input wire logic [23:0]	rsp_instr,
	input wire logic		window_wr_drop,
	input wire logic		pm_rd,
	input wire logic		pm_wr,
	input wire logic [23:0]	pm_addr,
	input wire logic [2:0]	pm_lane,
	input wire logic		pm_rvalid,
	input wire logic [23:0]	pm_rdata,
	input wire logic		ds_valid,
	input wire logic [15:0]	ds_addr
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	logic		tk;
	logic		hi_r;
	psab_op_t	op_r;
	assign tk = req_valid && req_ready;
	// remember the taken op so a late answer can be tied to its kind
	always_ff @(posedge clk) begin
		if (tk) begin
			op_r <= req_op;
			hi_r <= req_ea[15];
		end
	end
	a_win_addr: assert property (
		tk && req_op == PSAB_OP_DRD && req_ea[15] |=> pm_rd && pm_lane == 3'h3
		&& pm_addr == {1'b0, $past(window_page_reg), $past(req_ea[14:0])})
		else $error("window read address wrong");
	a_win_data: assert property (
		pm_rvalid && !req_ready && op_r == PSAB_OP_DRD && hi_r
		|=> rsp_valid && rsp_rdata == $past(pm_rdata[15:0]))
		else $error("window read data wrong");
	a_win_drop: assert property (
		tk && req_op == PSAB_OP_DWR && req_ea[15] |=> window_wr_drop && !pm_wr && !ds_valid)
		else $error("window write not dropped");
	a_tbl_addr: assert property (
		tk && req_op >= PSAB_OP_TRD |=> pm_addr == {$past(table_page_reg), $past(req_ea)})
		else $error("table address wrong");
	a_tbl_lane: assert property (
		tk && req_op >= PSAB_OP_TRD |=> pm_lane == ($past(req_hi) ? 3'h4
		: !$past(req_byte) ? 3'h3 : $past(req_ea[0]) ? 3'h2 : 3'h1))
		else $error("table lane wrong");
	a_fetch_addr: assert property (
		tk && req_op == PSAB_OP_FETCH |=> pm_rd && pm_lane == 3'h7
		&& pm_addr == {1'b0, $past(req_pc[22:1]), 1'b0})
		else $error("fetch address wrong");
	a_fetch_word: assert property (
		pm_rvalid && !req_ready && op_r == PSAB_OP_FETCH |=> rsp_instr == $past(pm_rdata))
		else $error("fetch word not whole");
	a_data_plain: assert property (
		tk && !req_ea[15] && (req_op == PSAB_OP_DRD || req_op == PSAB_OP_DWR)
		|=> ds_valid && ds_addr == $past(req_ea) && !pm_rd && !pm_wr)
		else $error("data access translated");
	c_cfg_tbl: cover property (tk && req_op == PSAB_OP_TRD && table_page_reg[7]);
	c_win_drop: cover property (window_wr_drop);
	c_win_read: cover property (rsp_valid && op_r == PSAB_OP_DRD);
endmodule
bind psab_top psab_chk u_chk (.clk, .srst, .req_valid, .req_op, .req_ea, .req_pc, .req_byte,
	.req_hi, .req_ready, .table_page_reg, .window_page_reg, .rsp_valid, .rsp_rdata, .rsp_instr,
	.window_wr_drop, .pm_rd, .pm_wr, .pm_addr, .pm_lane, .pm_rvalid, .pm_rdata, .ds_valid,
	.ds_addr);

// >>> bench/psab_pmem.sv
`timescale 1ns/1ps
// program memory stand-in: one read at a time, fast or slow
module psab_pmem
(
	input wire logic		clk,
	input wire logic		srst,
	input wire logic		slow,
	input wire logic		pm_rd,
	input wire logic [23:0]	pm_addr,
	output logic		pm_rvalid,
	output logic [23:0]	pm_rdata
);
	logic [23:0]	a;
	logic [23:0]	noise = 24'h00_0000;
	logic [1:0]	wt;
	logic		busy;
	// data lines scramble outside an answer so stale data never matches
	always @(posedge clk) begin
		pm_rvalid <= 1'b0;
		noise <= noise + 24'h13_5797;
		pm_rdata <= ~noise;
		if (srst) begin
			busy <= 1'b0;
		end else if (busy && wt == 2'h0) begin
			pm_rvalid <= 1'b1;
			pm_rdata <= {a[7:0], a[23:8]} ^ 24'h5a_c396;
			busy <= 1'b0;
		end else if (busy) begin
			wt <= wt - 2'h1;
		end else if (pm_rd) begin
			busy <= 1'b1;
			a <= pm_addr;
			wt <= slow ? 2'h2 : 2'h0;
		end
	end
endmodule

// >>> bench/psab_bench.sv
`timescale 1ns/1ps
module psab_bench
	import psab_pkg::*;
;
	logic		clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_byte = 1'b0, req_hi = 1'b0;
	logic		table_page_we = 1'b0, window_page_we = 1'b0, slow = 1'b0;
	psab_op_t	req_op = PSAB_OP_FETCH;
	logic [15:0]	req_ea = 16'h0000, req_wdata = 16'h0000, lf = 16'h0043;
	logic [22:0]	req_pc = 23'h00_0000;
	logic [7:0]	page_wdata = 8'h00, tp = 8'h00, wp = 8'h00;
	logic		req_ready, rsp_valid, window_wr_drop, pm_rd, pm_wr, pm_rvalid, ds_valid, ds_wr;
	logic [7:0]	table_page_reg, window_page_reg;
	logic [15:0]	rsp_rdata, ds_addr, ds_wdata;
	logic [23:0]	rsp_instr, pm_addr, pm_wdata, pm_rdata;
	logic [2:0]	pm_lane;
	int		n_mismatch = 0, checked = 0;
	always #4 clk = ~clk;
	psab_top dut (.clk, .srst, .req_valid, .req_op, .req_ea, .req_pc, .req_byte, .req_hi,
		.req_wdata, .req_ready, .table_page_we, .window_page_we, .page_wdata, .table_page_reg,
		.window_page_reg, .rsp_valid, .rsp_rdata, .rsp_instr, .window_wr_drop, .pm_rd, .pm_wr,
		.pm_addr, .pm_lane, .pm_wdata, .pm_rvalid, .pm_rdata, .ds_valid, .ds_wr, .ds_addr,
		.ds_wdata);
	psab_pmem mem (.clk, .srst, .slow, .pm_rd, .pm_addr, .pm_rvalid, .pm_rdata);
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one request, then expected strobes, address, lanes and answer
	task automatic run();
		logic [23:0]	a;
		logic [23:0]	w;
		logic [23:0]	wd;
		logic [2:0]	ln;
		logic		rd;
		int		k;
		k = 0;
		while (req_ready !== 1'b1 && k < 20) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (req_ready !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
		@(posedge clk);
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		rd = req_op == PSAB_OP_FETCH || req_op == PSAB_OP_TRD
			|| (req_op == PSAB_OP_DRD && req_ea[15]);
		a = req_op == PSAB_OP_FETCH ? {1'b0, req_pc[22:1], 1'b0}
			: req_op >= PSAB_OP_TRD ? {tp, req_ea} : {1'b0, wp, req_ea[14:0]};
		ln = req_op == PSAB_OP_FETCH ? 3'h7 : req_op < PSAB_OP_TRD ? 3'h3
			: req_hi ? 3'h4 : !req_byte ? 3'h3 : req_ea[0] ? 3'h2 : 3'h1;
		w = {a[7:0], a[23:8]} ^ 24'h5a_c396;
		// write data lands in the lane picked by hi, byte and ea bit 0
		wd = req_hi ? {req_wdata[7:0], 16'h0000} : !req_byte ? {8'h00, req_wdata}
			: req_ea[0] ? {8'h00, req_wdata[7:0], 8'h00} : {16'h0000, req_wdata[7:0]};
		chk("pages", {table_page_reg, window_page_reg}, {tp, wp});
		if (!req_ea[15] && (req_op == PSAB_OP_DRD || req_op == PSAB_OP_DWR)) begin
			chk("ds", {ds_valid, ds_wr, ds_addr}, {1'b1, req_op == PSAB_OP_DWR, req_ea});
			if (req_op == PSAB_OP_DWR) chk("ds_wdata", ds_wdata, req_wdata);
		end else if (req_op == PSAB_OP_DWR) begin
			chk("drop", {window_wr_drop, pm_wr}, 2'b10);
		end else begin
			chk("pm_addr", pm_addr, a);
			chk("pm_lane", {pm_rd, pm_wr, pm_lane}, {rd, !rd, ln});
			if (req_op == PSAB_OP_TWR) chk("pm_wdata", pm_wdata, wd);
		end
		if (rd) begin
			k = 0;
			while (rsp_valid !== 1'b1 && k < 20) begin
				@(posedge clk);
				#1;
				k++;
			end
			if (rsp_valid !== 1'b1) begin
				n_mismatch++;
				final_report();
			end
			if (req_op == PSAB_OP_FETCH) chk("instr", rsp_instr, w);
			chk("rdata", rsp_rdata, ln == 3'h4 ? w[23:16] : ln == 3'h2 ? w[15:8]
				: ln == 3'h1 ? w[7:0] : w[15:0]);
		end
	endtask
	// reset, then random ops with random page loads in between
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk("reset", {req_ready, table_page_reg, window_page_reg, pm_lane}, 20'h8_0000);
		$display("reset test done");
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			lf = nx(lf);
			req_ea <= lf;
			req_pc <= {lf[6:0], lf};
			req_wdata <= ~lf;
			lf = nx(lf);
			req_op <= psab_op_t'(3'(lf[2:0] % 3'h5));
			req_byte <= lf[3];
			req_hi <= lf[4] & lf[3];
			slow <= lf[5];
			table_page_we <= lf[6];
			window_page_we <= lf[7];
			page_wdata <= lf[15:8];
			if (lf[6]) tp = lf[15:8];
			if (lf[7]) wp = lf[15:8];
			@(posedge clk);
			table_page_we <= 1'b0;
			window_page_we <= 1'b0;
			#1;
			run();
		end
		$display("random op test done");
		final_report();
	end
endmodule
